// *** rtl/ttcu_pkg.sv ***
// Constants and types shared by the three timer/counter unit
package ttcu_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [3:0] OFS_TIMER_MODE   = 4'h0;
	localparam logic [3:0] OFS_TIMER_CTRL   = 4'h1;
	localparam logic [3:0] OFS_CLOCK_CTRL   = 4'h2;
	localparam logic [3:0] OFS_FIRST_LOW    = 4'h3;
	localparam logic [3:0] OFS_SECOND_LOW   = 4'h4;
	localparam logic [3:0] OFS_FIRST_HIGH   = 4'h5;
	localparam logic [3:0] OFS_SECOND_HIGH  = 4'h6;
	localparam logic [3:0] OFS_THIRD_CTRL   = 4'h7;
	localparam logic [3:0] OFS_THIRD_MODE   = 4'h8;
	localparam logic [3:0] OFS_CAPTURE_LOW  = 4'h9;
	localparam logic [3:0] OFS_CAPTURE_HIGH = 4'hA;
	localparam logic [3:0] OFS_THIRD_LOW    = 4'hB;
	localparam logic [3:0] OFS_THIRD_HIGH   = 4'hC;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int TIMER_MODE_REGISTER_T0_MODE = 0;
	localparam int TIMER_MODE_REGISTER_T0_CT   = 2;
	localparam int TIMER_MODE_REGISTER_T0_GATE = 3;
	localparam int TIMER_MODE_REGISTER_T1_MODE = 4;
	localparam int TIMER_MODE_REGISTER_T1_CT   = 6;
	localparam int TIMER_MODE_REGISTER_T1_GATE = 7;
	localparam int TIMER_CONTROL_REGISTER_RUN0    = 4;
	localparam int TIMER_CONTROL_REGISTER_OVF0    = 5;
	localparam int TIMER_CONTROL_REGISTER_RUN1    = 6;
	localparam int TIMER_CONTROL_REGISTER_OVF1    = 7;
	localparam int CLOCK_CONTROL_REGISTER_SPD0   = 3;
	localparam int CLOCK_CONTROL_REGISTER_SPD1   = 4;
	localparam int CLOCK_CONTROL_REGISTER_SPD2   = 5;
	localparam int THIRD_TIMER_CONTROL_REGISTER_CPRL   = 0;
	localparam int THIRD_TIMER_CONTROL_REGISTER_CT2    = 1;
	localparam int THIRD_TIMER_CONTROL_REGISTER_RUN2   = 2;
	localparam int THIRD_TIMER_CONTROL_REGISTER_EXEN   = 3;
	localparam int THIRD_TIMER_CONTROL_REGISTER_TRANSMIT_BAUD_SELECT   = 4;
	localparam int THIRD_TIMER_CONTROL_REGISTER_RCLK   = 5;
	localparam int THIRD_TIMER_CONTROL_REGISTER_EXF    = 6;
	localparam int THIRD_TIMER_CONTROL_REGISTER_OVF2   = 7;
	localparam int THIRD_TIMER_MODE_REGISTER_UDEN   = 0;
	localparam int THIRD_TIMER_MODE_REGISTER_CLKOE  = 1;
	localparam int THIRD_TIMER_MODE_REGISTER_ACLR   = 3;

	////////////////////////////////////////////////////////////////////////
	// Reset values and timing
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] CNT_ONES  = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO  = 16'h0000;
	localparam int          DIV_SLOW  = 12;
	localparam int          DIV_FAST  = 4;
	localparam logic [3:0]  PRE_LAST  = 4'(DIV_SLOW - 1);
	localparam logic [1:0]  FAST_LAST = 2'(DIV_FAST - 1);

	typedef enum logic [1:0] {
		TTCU_MODE_13,
		TTCU_MODE_16,
		TTCU_MODE_RELOAD8,
		TTCU_MODE_SPLIT
	} ttcu_mode_type;

endpackage : ttcu_pkg

// *** rtl/ttcu_sampler.sv ***
// Count pin sampler: one sample per machine cycle, falling edge pulse
module ttcu_sampler (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic sample_i,
	input  wire logic pin_i,
	output logic      fall_o
);

	typedef struct packed {
		logic last;
		logic fall;
	} ttcu_samp_type;

	ttcu_samp_type st_r;
	ttcu_samp_type st_nxt;

	////////////////////////////////////////////////////////////////////////
	// High sample then low sample gives one pulse
	always_comb begin
		st_nxt      = st_r;
		st_nxt.fall = sample_i & st_r.last & ~pin_i;
		if (sample_i) begin
			st_nxt.last = pin_i;
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign fall_o = st_r.fall;

	sequence s_high_low;
		sample_i && st_r.last && !pin_i;
	endsequence

	AST_SAMPLE_FALL: assert property (@(posedge clk_i) disable iff (!reset_n_i) s_high_low |=> fall_o) else $error("missed falling edge");
	AST_SAMPLE_ONLY: assert property (@(posedge clk_i) disable iff (!reset_n_i) !sample_i |=> !fall_o) else $error("edge without sample");

endmodule : ttcu_sampler

// *** rtl/ttcu_top.sv ***
// Three timer/counter unit with plain register port
//
// Chosen here: the placing of the registers and the strobed register port.
module ttcu_top (
	input  wire logic                    clk_i,
	input  wire logic                    reset_n_i,
	input  wire logic [ttcu_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [ttcu_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output logic      [ttcu_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                    first_count_pin_i,
	input  wire logic                    second_count_pin_i,
	input  wire logic                    third_count_pin_i,
	input  wire logic                    first_gate_pin_i,
	input  wire logic                    second_gate_pin_i,
	input  wire logic                    trigger_direction_pin_i,
	output logic                         first_overflow_o,
	output logic                         second_overflow_o,
	output logic                         third_irq_o,
	output logic                         clock_out_o
);

	typedef struct packed {
		logic [3:0] pre;
		logic [7:0] timer_mode_register;
		logic [7:0] timer_control_register;
		logic [7:0] clock_control_register;
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic [7:0] third_timer_control_register;
		logic [7:0] third_timer_mode_register;
		logic [7:0] cap_l;
		logic [7:0] cap_h;
		logic [7:0] tl2;
		logic [7:0] th2;
		logic       clk_out;
		logic [7:0] rdata;
	} ttcu_state_type;

	ttcu_state_type st_r;
	ttcu_state_type st_nxt;

	logic                  tick12;
	logic                  tick4;
	logic                  tick0;
	logic                  tick1;
	logic                  tick2;
	logic                  fall0;
	logic                  fall1;
	logic                  fall2;
	logic                  fall_ex;
	logic                  inc0;
	logic                  inc0h;
	logic                  inc1;
	logic                  inc2;
	logic                  run1_eff;
	logic                  split0;
	logic                  baud;
	logic                  clkout;
	logic                  updown;
	logic                  cap_mode;
	logic                  t2_wrap;
	logic                  t2_match;
	logic [1:0]            mode0;
	logic [1:0]            mode1;
	logic [15:0]           cnt2;
	logic [15:0]           capv;

	////////////////////////////////////////////////////////////////////////
	// One step of a first/second timer: returns {overflow, high, low}
	function automatic logic [16:0] step01(input logic [1:0] mode,
			input logic [7:0] th, input logic [7:0] tl, input logic inc);
		logic [16:0] r;
		r = {1'b0, th, tl};
		if (inc) begin
			unique case (ttcu_pkg::ttcu_mode_type'(mode))
				ttcu_pkg::TTCU_MODE_13: begin
					// Upper three low bits are ignored and kept
					r[4:0] = tl[4:0] + 5'h01;
					if (tl[4:0] == 5'h1F) begin
						r[15:8] = th + 8'h01;
						r[16]   = (th == 8'hFF);
					end
				end
				ttcu_pkg::TTCU_MODE_16: begin
					r[15:0] = {th, tl} + 16'h0001;
					r[16]   = ({th, tl} == ttcu_pkg::CNT_ONES);
				end
				ttcu_pkg::TTCU_MODE_RELOAD8: begin
					r[7:0] = (tl == 8'hFF) ? th : tl + 8'h01;
					r[16]  = (tl == 8'hFF);
				end
				ttcu_pkg::TTCU_MODE_SPLIT: begin
					r[7:0] = tl + 8'h01;
					r[16]  = (tl == 8'hFF);
				end
			endcase
		end
		return r;
	endfunction : step01

	////////////////////////////////////////////////////////////////////////
	// Machine cycle prescaler shared by all timers
	assign tick12 = (st_r.pre == ttcu_pkg::PRE_LAST);
	assign tick4  = (st_r.pre[1:0] == ttcu_pkg::FAST_LAST);
	assign tick0  = st_r.clock_control_register[ttcu_pkg::CLOCK_CONTROL_REGISTER_SPD0] ? tick4 : tick12;
	assign tick1  = st_r.clock_control_register[ttcu_pkg::CLOCK_CONTROL_REGISTER_SPD1] ? tick4 : tick12;
	assign tick2  = st_r.clock_control_register[ttcu_pkg::CLOCK_CONTROL_REGISTER_SPD2] ? tick4 : tick12;

	// Pin samplers run at each timer's own machine cycle rate
	ttcu_sampler u_samp0 (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.sample_i  (tick0),
		.pin_i     (first_count_pin_i),
		.fall_o    (fall0)
	);
	ttcu_sampler u_samp1 (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.sample_i  (tick1),
		.pin_i     (second_count_pin_i),
		.fall_o    (fall1)
	);
	ttcu_sampler u_samp2 (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.sample_i  (tick2),
		.pin_i     (third_count_pin_i),
		.fall_o    (fall2)
	);
	ttcu_sampler u_sampx (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.sample_i  (tick2),
		.pin_i     (trigger_direction_pin_i),
		.fall_o    (fall_ex)
	);

	////////////////////////////////////////////////////////////////////////
	// Count enables for the first two timers
	assign mode0  = st_r.timer_mode_register[ttcu_pkg::TIMER_MODE_REGISTER_T0_MODE +: 2];
	assign mode1  = st_r.timer_mode_register[ttcu_pkg::TIMER_MODE_REGISTER_T1_MODE +: 2];
	assign split0 = (mode0 == 2'(ttcu_pkg::TTCU_MODE_SPLIT));
	// Beside a split first timer, the second runs whenever not split itself
	assign run1_eff = split0 ? 1'b1 : st_r.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_RUN1];
	assign inc0 = st_r.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_RUN0]
		& (~st_r.timer_mode_register[ttcu_pkg::TIMER_MODE_REGISTER_T0_GATE] | first_gate_pin_i)
		& (st_r.timer_mode_register[ttcu_pkg::TIMER_MODE_REGISTER_T0_CT] ? fall0 : tick0);
	assign inc1 = run1_eff
		& (mode1 != 2'(ttcu_pkg::TTCU_MODE_SPLIT))
		& (~st_r.timer_mode_register[ttcu_pkg::TIMER_MODE_REGISTER_T1_GATE] | second_gate_pin_i)
		& (st_r.timer_mode_register[ttcu_pkg::TIMER_MODE_REGISTER_T1_CT] ? fall1 : tick1);
	// Split high byte ignores pin and gate: clock only
	assign inc0h = split0 & st_r.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_RUN1] & tick0;

	////////////////////////////////////////////////////////////////////////
	// Third timer mode decode
	assign cnt2     = {st_r.th2, st_r.tl2};
	assign capv     = {st_r.cap_h, st_r.cap_l};
	assign baud     = st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_RCLK]
		| st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_TRANSMIT_BAUD_SELECT];
	assign cap_mode = st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_CPRL] & ~baud;
	assign clkout   = st_r.third_timer_mode_register[ttcu_pkg::THIRD_TIMER_MODE_REGISTER_CLKOE]
		& ~st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_CT2]
		& ~st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_CPRL];
	assign updown   = ~cap_mode & ~baud & ~clkout
		& st_r.third_timer_mode_register[ttcu_pkg::THIRD_TIMER_MODE_REGISTER_UDEN];
	// Clock-out counts every second clock so a half period is 2*(65536-cap)
	assign inc2 = st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_RUN2]
		& (st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_CT2] ? fall2
		: (clkout ? st_r.pre[0] : tick2));
	assign t2_wrap  = (cnt2 == ttcu_pkg::CNT_ONES);
	assign t2_match = (cnt2 == capv);

	////////////////////////////////////////////////////////////////////////
	// Next state: counting first, then register writes override
	always_comb begin
		logic [16:0] s0;
		logic [16:0] s1;
		logic [15:0] c2;
		logic        ovf0_set;
		logic        ovf1_set;
		logic        ovf2_set;
		logic        external_event_flag_set;
		logic        external_event_flag_tog;
		st_nxt   = st_r;
		ovf2_set = 1'b0;
		external_event_flag_set = 1'b0;
		external_event_flag_tog = 1'b0;
		c2       = cnt2;
		st_nxt.pre = tick12 ? 4'h0 : st_r.pre + 4'h1;

		// First and second timers
		s0 = step01(mode0, st_r.th0, st_r.tl0, inc0);
		s1 = step01(mode1, st_r.th1, st_r.tl1, inc1);
		st_nxt.tl0 = s0[7:0];
		st_nxt.th0 = split0 ? (st_r.th0 + {7'h00, inc0h}) : s0[15:8];
		st_nxt.tl1 = s1[7:0];
		st_nxt.th1 = s1[15:8];
		ovf0_set = s0[16];
		// Split high byte owns the second overflow flag
		ovf1_set = split0 ? (inc0h & (st_r.th0 == 8'hFF)) : s1[16];

		// Third timer
		if (cap_mode) begin
			if (inc2) begin
				c2 = cnt2 + 16'h0001;
				ovf2_set = t2_wrap;
			end
			if (st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_EXEN] && fall_ex) begin
				st_nxt.cap_l = st_r.tl2;
				st_nxt.cap_h = st_r.th2;
				external_event_flag_set = 1'b1;
				if (st_r.third_timer_mode_register[ttcu_pkg::THIRD_TIMER_MODE_REGISTER_ACLR]) begin
					c2 = ttcu_pkg::CNT_ZERO;
				end
			end
		end else if (baud || clkout) begin
			if (inc2) begin
				c2 = t2_wrap ? capv : cnt2 + 16'h0001;
				if (t2_wrap && clkout) begin
					st_nxt.clk_out = ~st_r.clk_out;
				end
			end
			if (baud && st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_EXEN] && fall_ex) begin
				external_event_flag_set = 1'b1;
			end
		end else if (!updown) begin
			if (inc2) begin
				c2 = t2_wrap ? capv : cnt2 + 16'h0001;
				ovf2_set = t2_wrap;
			end
			if (st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_EXEN] && fall_ex) begin
				c2 = capv;
				external_event_flag_set = 1'b1;
			end
		end else if (inc2) begin
			if (trigger_direction_pin_i) begin
				c2 = t2_wrap ? capv : cnt2 + 16'h0001;
				ovf2_set = t2_wrap;
				external_event_flag_tog = t2_wrap;
			end else begin
				c2 = t2_match ? ttcu_pkg::CNT_ONES : cnt2 - 16'h0001;
				ovf2_set = t2_match;
				external_event_flag_tog = t2_match;
			end
		end
		st_nxt.tl2 = c2[7:0];
		st_nxt.th2 = c2[15:8];

		// Register writes; hardware flag sets win over a clearing write
		if (wr_i) begin
			unique case (addr_i)
				ttcu_pkg::OFS_TIMER_MODE:   st_nxt.timer_mode_register  = wdata_i;
				ttcu_pkg::OFS_TIMER_CTRL:   st_nxt.timer_control_register  = {wdata_i[7:4], 4'h0};
				ttcu_pkg::OFS_CLOCK_CTRL:   st_nxt.clock_control_register = {2'h0, wdata_i[5:3], 3'h0};
				ttcu_pkg::OFS_FIRST_LOW:    st_nxt.tl0   = wdata_i;
				ttcu_pkg::OFS_SECOND_LOW:   st_nxt.tl1   = wdata_i;
				ttcu_pkg::OFS_FIRST_HIGH:   st_nxt.th0   = wdata_i;
				ttcu_pkg::OFS_SECOND_HIGH:  st_nxt.th1   = wdata_i;
				ttcu_pkg::OFS_THIRD_CTRL:   st_nxt.third_timer_control_register = wdata_i;
				ttcu_pkg::OFS_THIRD_MODE:   st_nxt.third_timer_mode_register = {4'h0, wdata_i[3], 1'b0, wdata_i[1:0]};
				ttcu_pkg::OFS_CAPTURE_LOW:  st_nxt.cap_l = wdata_i;
				ttcu_pkg::OFS_CAPTURE_HIGH: st_nxt.cap_h = wdata_i;
				ttcu_pkg::OFS_THIRD_LOW:    st_nxt.tl2   = wdata_i;
				ttcu_pkg::OFS_THIRD_HIGH:   st_nxt.th2   = wdata_i;
				default: ;
			endcase
		end
		st_nxt.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_OVF0] = st_nxt.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_OVF0] | ovf0_set;
		st_nxt.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_OVF1] = st_nxt.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_OVF1] | ovf1_set;
		st_nxt.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_OVF2] = st_nxt.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_OVF2] | ovf2_set;
		st_nxt.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_EXF] = (st_nxt.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_EXF] ^ external_event_flag_tog)
			| external_event_flag_set;

		// Read data stand for exactly one cycle; unmapped reads give zero
		st_nxt.rdata = ttcu_pkg::RST_BYTE;
		if (rd_i) begin
			unique case (addr_i)
				ttcu_pkg::OFS_TIMER_MODE:   st_nxt.rdata = st_r.timer_mode_register;
				ttcu_pkg::OFS_TIMER_CTRL:   st_nxt.rdata = st_r.timer_control_register;
				ttcu_pkg::OFS_CLOCK_CTRL:   st_nxt.rdata = st_r.clock_control_register;
				ttcu_pkg::OFS_FIRST_LOW:    st_nxt.rdata = st_r.tl0;
				ttcu_pkg::OFS_SECOND_LOW:   st_nxt.rdata = st_r.tl1;
				ttcu_pkg::OFS_FIRST_HIGH:   st_nxt.rdata = st_r.th0;
				ttcu_pkg::OFS_SECOND_HIGH:  st_nxt.rdata = st_r.th1;
				ttcu_pkg::OFS_THIRD_CTRL:   st_nxt.rdata = st_r.third_timer_control_register;
				ttcu_pkg::OFS_THIRD_MODE:   st_nxt.rdata = st_r.third_timer_mode_register;
				ttcu_pkg::OFS_CAPTURE_LOW:  st_nxt.rdata = st_r.cap_l;
				ttcu_pkg::OFS_CAPTURE_HIGH: st_nxt.rdata = st_r.cap_h;
				ttcu_pkg::OFS_THIRD_LOW:    st_nxt.rdata = st_r.tl2;
				ttcu_pkg::OFS_THIRD_HIGH:   st_nxt.rdata = st_r.th2;
				default: ;
			endcase
		end
	end

	// State register; all control resets to zero (divide by 12)
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign rdata_o           = st_r.rdata;
	assign first_overflow_o  = st_r.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_OVF0];
	assign second_overflow_o = st_r.timer_control_register[ttcu_pkg::TIMER_CONTROL_REGISTER_OVF1];
	// External flag is silent in up/down mode
	assign third_irq_o = st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_OVF2]
		| (st_r.third_timer_control_register[ttcu_pkg::THIRD_TIMER_CONTROL_REGISTER_EXF] & ~updown);
	assign clock_out_o = st_r.clk_out;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_t0_wrap16;
		!wr_i && inc0 && mode0 == 2'h1 && {st_r.th0, st_r.tl0} == 16'hFFFF;
	endsequence
	sequence s_t2_down_match;
		!wr_i && inc2 && updown && !trigger_direction_pin_i && t2_match;
	endsequence
	sequence s_capture;
		!wr_i && cap_mode && st_r.third_timer_control_register[3] && fall_ex;
	endsequence

	AST_T0_WRAP16: assert property (s_t0_wrap16 |=> {st_r.th0, st_r.tl0} == 16'h0000 && first_overflow_o) else $error("16-bit wrap wrong");
	AST_T0_RELOAD: assert property (!wr_i && inc0 && mode0 == 2'h2 && st_r.tl0 == 8'hFF |=> st_r.tl0 == $past(st_r.th0) && $stable(st_r.th0) && first_overflow_o) else $error("8-bit reload wrong");
	AST_T1_FROZEN: assert property (!wr_i && mode1 == 2'h3 |=> $stable({st_r.th1, st_r.tl1})) else $error("split second timer moved");
	AST_GATE_OFF: assert property (!st_r.timer_control_register[4] || (st_r.timer_mode_register[3] && !first_gate_pin_i) |-> !inc0) else $error("gated count enabled");
	AST_T2_STOPPED: assert property (!wr_i && !st_r.third_timer_control_register[2] && !fall_ex |=> $stable(cnt2)) else $error("stopped third timer moved");
	AST_T2_CAPTURE: assert property (s_capture |=> capv == $past(cnt2) && st_r.third_timer_control_register[6]) else $error("capture wrong");
	AST_T2_AUTOCLR: assert property (s_capture and st_r.third_timer_mode_register[3] |=> cnt2 == 16'h0000) else $error("auto clear missed");
	AST_T2_DOWN_ONES: assert property (s_t2_down_match |=> cnt2 == 16'hFFFF && st_r.third_timer_control_register[7] && st_r.third_timer_control_register[6] != $past(st_r.third_timer_control_register[6])) else $error("down reload wrong");
	AST_BAUD_NOFLAG: assert property (!wr_i && baud && !st_r.third_timer_control_register[7] |=> !st_r.third_timer_control_register[7]) else $error("baud mode set overflow");
	AST_CLKOUT_TOGGLE: assert property (!wr_i && clkout && inc2 && t2_wrap |=> clock_out_o != $past(clock_out_o) && cnt2 == capv) else $error("clock out no toggle");
	AST_SPEED_FAST: assert property (st_r.clock_control_register[5] && !wr_i && !st_r.third_timer_control_register[1] && st_r.third_timer_control_register[2] && !clkout && !updown |-> inc2 == tick4) else $error("fast tick not used");

endmodule : ttcu_top

// *** test/ttcu_pins.sv ***
// Pin-side model: count, gate and trigger pin drivers
module ttcu_pins (
	input  wire logic       clk_i,
	output logic      [2:0] cnt_o,
	output logic      [1:0] gate_o,
	output logic            trig_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins idle high so that the first drop is a real fall
	initial begin
		cnt_o = 3'h7;
		gate_o = 2'h3;
		trig_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Falls on count pin w; 30-clock halves span two slow machine cycles
	task automatic pulse(input int w, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (30) @(posedge clk_i);
			cnt_o[w] <= 1'b0;
			repeat (30) @(posedge clk_i);
			cnt_o[w] <= 1'b1;
		end
	endtask : pulse

	// One trigger fall, held past a slow tick on each side
	task automatic trig_fall;
		repeat (30) @(posedge clk_i);
		trig_o <= 1'b0;
		repeat (30) @(posedge clk_i);
		trig_o <= 1'b1;
	endtask : trig_fall

	// Trigger level as up/down direction, changed on a clock edge
	task automatic set_trig(input logic v);
		@(posedge clk_i);
		trig_o <= v;
	endtask : set_trig

	// Gate pin levels, changed on a clock edge
	task automatic set_gate(input logic [1:0] v);
		@(posedge clk_i);
		gate_o <= v;
	endtask : set_gate
endmodule : ttcu_pins

// *** test/ttcu_top_test.sv ***
// Self-checking bench for the three timer/counter unit
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module ttcu_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i = 1'b0;
	logic       reset_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic [7:0] rdata_o, d, e, r;
	logic [2:0] cnt;
	logic [1:0] gate;
	logic       trig, ovf0, ovf1, irq, cko;
	int         fails = 0;
	int         n_tests = 0;
	int         k, h, l, per;

	ttcu_pins pins (.clk_i(clk_i), .cnt_o(cnt), .gate_o(gate), .trig_o(trig));
	ttcu_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.first_count_pin_i(cnt[0]), .second_count_pin_i(cnt[1]),
		.third_count_pin_i(cnt[2]), .first_gate_pin_i(gate[0]),
		.second_gate_pin_i(gate[1]), .trigger_direction_pin_i(trig),
		.first_overflow_o(ovf0), .second_overflow_o(ovf1),
		.third_irq_o(irq), .clock_out_o(cko));

	// 125 MHz clock
	always #4 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////
	// Bus tasks; a gap cycle keeps strobes from being set twice at one edge
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask : rd

	// Wait n edges, then step off the edge before sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	task automatic done(input string s);
		$display("Test %s over", s);
	endtask : done

	task automatic wrap_up;
		$display("Compares %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	// Watchdog: the tests need about 1100 cycles, this allows 25000
	initial begin
		#200000;
		fails++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		r = {1'b0, 7'($urandom(32'h5516788f))};
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		// All registers and unmapped offsets read zero after reset
		for (k = 0; k < 16; k++) begin
			rd(4'(k), d);
			`CHK(d, 8'h00)
		end
		done("reset");
		// Sixteen-bit timer at divide by 4 wraps into its flag
		wr(ttcu_pkg::OFS_CLOCK_CTRL, 8'h08);
		wr(ttcu_pkg::OFS_TIMER_MODE, 8'h01);
		wr(ttcu_pkg::OFS_FIRST_LOW, 8'hFE);
		wr(ttcu_pkg::OFS_FIRST_HIGH, 8'hFF);
		wr(ttcu_pkg::OFS_TIMER_CTRL, 8'h10);
		tick(20);
		`CHK(ovf0, 1'b1)
		rd(ttcu_pkg::OFS_FIRST_HIGH, d);
		`CHK(d, 8'h00)
		done("wide");
		// Reload mode keeps the high byte and refills the low one
		wr(ttcu_pkg::OFS_TIMER_CTRL, 8'h00);
		wr(ttcu_pkg::OFS_TIMER_MODE, 8'h02);
		wr(ttcu_pkg::OFS_FIRST_HIGH, r);
		wr(ttcu_pkg::OFS_FIRST_LOW, 8'hFE);
		wr(ttcu_pkg::OFS_TIMER_CTRL, 8'h10);
		tick(20);
		`CHK(ovf0, 1'b1)
		rd(ttcu_pkg::OFS_FIRST_HIGH, d);
		`CHK(d, r)
		rd(ttcu_pkg::OFS_FIRST_LOW, d);
		`CHK(8'(d - r) < 8'h08, 1'b1)
		done("reload");
		// Pin counting is held off while the gate pin is low
		wr(ttcu_pkg::OFS_TIMER_CTRL, 8'h00);
		wr(ttcu_pkg::OFS_CLOCK_CTRL, 8'h00);
		wr(ttcu_pkg::OFS_TIMER_MODE, 8'h0D);
		wr(ttcu_pkg::OFS_FIRST_LOW, 8'h00);
		wr(ttcu_pkg::OFS_FIRST_HIGH, 8'h00);
		pins.set_gate(2'h2);
		wr(ttcu_pkg::OFS_TIMER_CTRL, 8'h10);
		pins.pulse(0, 3);
		rd(ttcu_pkg::OFS_FIRST_LOW, d);
		`CHK(d, 8'h00)
		pins.set_gate(2'h3);
		pins.pulse(0, 3);
		tick(30);
		rd(ttcu_pkg::OFS_FIRST_LOW, d);
		`CHK(d, 8'h03)
		done("gate");
		// Split: second timer frozen, first high byte on second run bit
		wr(ttcu_pkg::OFS_TIMER_MODE, 8'h10);
		wr(ttcu_pkg::OFS_TIMER_CTRL, 8'h40);
		tick(50);
		wr(ttcu_pkg::OFS_TIMER_MODE, 8'h33);
		rd(ttcu_pkg::OFS_SECOND_LOW, d);
		tick(50);
		rd(ttcu_pkg::OFS_SECOND_LOW, e);
		`CHK(e, d)
		rd(ttcu_pkg::OFS_FIRST_LOW, d);
		`CHK(d, 8'h03)
		rd(ttcu_pkg::OFS_FIRST_HIGH, d);
		`CHK(d != 8'h00, 1'b1)
		done("split");
		// Capture on trigger fall while the third timer is stopped
		wr(ttcu_pkg::OFS_TIMER_CTRL, 8'h00);
		wr(ttcu_pkg::OFS_THIRD_LOW, 8'h34);
		wr(ttcu_pkg::OFS_THIRD_HIGH, 8'h12);
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h09);
		pins.trig_fall();
		tick(30);
		rd(ttcu_pkg::OFS_CAPTURE_HIGH, d);
		`CHK(d, 8'h12)
		rd(ttcu_pkg::OFS_THIRD_LOW, d);
		`CHK(d, 8'h34)
		`CHK(irq, 1'b1)
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h09);
		wr(ttcu_pkg::OFS_THIRD_MODE, 8'h08);
		wr(ttcu_pkg::OFS_THIRD_LOW, 8'h55);
		pins.trig_fall();
		tick(30);
		rd(ttcu_pkg::OFS_THIRD_LOW, d);
		`CHK(d, 8'h00)
		rd(ttcu_pkg::OFS_CAPTURE_LOW, d);
		`CHK(d, 8'h55)
		done("capture");
		// Reload-up wrap refills the count from the capture bytes
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h00);
		wr(ttcu_pkg::OFS_THIRD_MODE, 8'h00);
		wr(ttcu_pkg::OFS_CAPTURE_HIGH, r);
		wr(ttcu_pkg::OFS_CAPTURE_LOW, 8'h00);
		wr(ttcu_pkg::OFS_THIRD_HIGH, 8'hFF);
		wr(ttcu_pkg::OFS_THIRD_LOW, 8'hFC);
		wr(ttcu_pkg::OFS_CLOCK_CTRL, 8'h20);
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h04);
		tick(40);
		rd(ttcu_pkg::OFS_THIRD_HIGH, d);
		`CHK(d, r)
		`CHK(irq, 1'b1)
		done("reload up");
		// Baud mode wraps the same way but leaves the flag clear
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h00);
		wr(ttcu_pkg::OFS_THIRD_HIGH, 8'hFF);
		wr(ttcu_pkg::OFS_THIRD_LOW, 8'hFC);
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h14);
		tick(80);
		rd(ttcu_pkg::OFS_THIRD_CTRL, d);
		`CHK(d[7], 1'b0)
		rd(ttcu_pkg::OFS_THIRD_HIGH, d);
		`CHK(d, r)
		done("baud");
		// Clock out: period is four times the distance to 65536
		per = 4 * (65536 - 'hFFFE);
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h00);
		wr(ttcu_pkg::OFS_CAPTURE_HIGH, 8'hFF);
		wr(ttcu_pkg::OFS_CAPTURE_LOW, 8'hFE);
		wr(ttcu_pkg::OFS_THIRD_HIGH, 8'hFF);
		wr(ttcu_pkg::OFS_THIRD_LOW, 8'hFE);
		wr(ttcu_pkg::OFS_THIRD_MODE, 8'h02);
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h04);
		for (k = 0; k < 40 && cko !== 1'b0; k++) tick(1);
		for (k = 0; k < 40 && cko !== 1'b1; k++) tick(1);
		for (h = 0; h < 40 && cko === 1'b1; h++) tick(1);
		for (l = 0; l < 40 && cko === 1'b0; l++) tick(1);
		`CHK(h + l, per)
		`CHK(h, per / 2)
		`CHK(irq, 1'b0)
		done("clock out");
		// Up/down: pin low counts down past the capture value to all ones
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h00);
		wr(ttcu_pkg::OFS_THIRD_MODE, 8'h01);
		wr(ttcu_pkg::OFS_CAPTURE_HIGH, 8'h00);
		wr(ttcu_pkg::OFS_CAPTURE_LOW, 8'h02);
		wr(ttcu_pkg::OFS_THIRD_HIGH, 8'h00);
		wr(ttcu_pkg::OFS_THIRD_LOW, 8'h04);
		pins.set_trig(1'b0);
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h04);
		tick(20);
		rd(ttcu_pkg::OFS_THIRD_HIGH, d);
		`CHK(d, 8'hFF)
		rd(ttcu_pkg::OFS_THIRD_CTRL, d);
		`CHK(d, 8'hC4)
		// External flag alone must stay silent in this mode
		wr(ttcu_pkg::OFS_THIRD_CTRL, 8'h44);
		tick(1);
		`CHK(irq, 1'b0)
		// Pin high counts up; the wrap reloads from the capture bytes
		pins.set_trig(1'b1);
		tick(40);
		rd(ttcu_pkg::OFS_THIRD_HIGH, d);
		`CHK(d, 8'h00)
		`CHK(irq, 1'b1)
		done("up down");
		wrap_up();
	end
endmodule : ttcu_top_test
